// File: rtl/timer_pair.v
// Purpose: two timer/counters with an AXI4-Lite register slave
// Assumes: CLK_SYS is the oscillator; pins are asynchronous
// Notes:   overflow flags drive the interrupt request outputs
//
// Contract
// - run enable counts low byte; low overflow bumps high; high overflow sets flag
// - starting the count leaves both count bytes as they were
// - source bit picks peripheral cycle (0) or count pin edges (1)
// - timer counts once per peripheral cycle of six peripheral clocks
// - timer rate is oscillator over twelve, or over six in double speed
// - count pin sampled each peripheral cycle; high then low counts one
// - edge recognition spans two peripheral cycles
// - two-bit mode pair per unit selects one of four modes
// - unit 0 uses low mode nibble and control bits 4 and 5
// - input passes only when run set and gate off or gate pin high; unit 1 passes with run clear while unit 0 is in mode 3
// - roll-over from all ones sets the unit overflow flag; in unit 0 mode 3 unit 1 roll-over sets none, unit 0 high byte sets flag 1
// - mode 0 is a 13-bit count with a modulo 32 prescaler
// - gate enable is mode bit 7 for unit 1, bit 3 for unit 0
// - unit 1 mode 0 uses its own run, flag and gate pin; while unit 0 is in mode 3 it ignores its run bit and sets no flag
// - mode 1 cascades both bytes into a 16-bit count
// - mode 2 reloads low byte from high byte on overflow
// - vectoring to the interrupt routine clears the overflow flag
`timescale 1ns/10ps
`include "timer_regs.vh"

module timer_pair (
  // clock and reset
  input  wire        CLK_SYS,
  input  wire        RST,
  // write address channel
  input  wire [7:0]  AWADDR,
  input  wire        AWVALID,
  output reg         AWREADY,
  // write data channel
  input  wire [31:0] WDATA,
  input  wire [3:0]  WSTRB,
  input  wire        WVALID,
  output reg         WREADY,
  // write response channel
  output reg  [1:0]  BRESP,
  output reg         BVALID,
  input  wire        BREADY,
  // read address channel
  input  wire [7:0]  ARADDR,
  input  wire        ARVALID,
  output reg         ARREADY,
  // read data channel
  output reg  [31:0] RDATA,
  output reg  [1:0]  RRESP,
  output reg         RVALID,
  input  wire        RREADY,
  // external pins
  input  wire        COUNT_PIN0,
  input  wire        COUNT_PIN1,
  input  wire        GATE_PIN0,
  input  wire        GATE_PIN1,
  // interrupt vector acknowledge
  input  wire        VECTOR_ACK0,
  input  wire        VECTOR_ACK1,
  // overflow interrupt requests
  output reg         OVF_IRQ0,
  output reg         OVF_IRQ1
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  reg  [7:0] mode_ff;
  reg        run0_ff;
  reg        run1_ff;
  reg        x2_ff;
  reg  [3:0] div_ff;
  reg        per_tick_ff;
  reg  [3:0] pin_s1_ff;
  reg  [3:0] pin_s2_ff;
  reg  [3:0] pin_s3_ff;
  reg  [3:0] pin_lvl_ff;
  reg        sample0_ff;
  reg        sample1_ff;
  reg        aw_got_ff;
  reg        w_got_ff;
  reg  [7:0] awaddr_ff;
  reg  [7:0] wdata_ff;
  reg        wlane_ff;
  reg  [7:0] rd_byte;
  reg        rd_hit;
  reg        wr_hit;
  wire       do_write;
  wire [3:0] pin_raw;
  wire [3:0] div_last;
  wire       edge0;
  wire       edge1;
  wire       src0;
  wire       src1;
  wire       gate_ok0;
  wire       gate_ok1;
  wire       t0_split;
  wire       run1_eff;
  wire       tick0;
  wire       tick1;
  wire       tick0_high;
  wire [7:0] low0;
  wire [7:0] high0;
  wire [7:0] low1;
  wire [7:0] high1;
  wire       ovf0_low;
  wire       ovf0_high;
  wire       ovf1_low;
  wire       set_ovf0;
  wire       set_ovf1;
  wire       wr_ctrl;
  wire       clr_ovf0;
  wire       clr_ovf1;
  wire [7:0] rd_addr;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // pin order: count0, count1, gate0, gate1
  assign pin_raw = {GATE_PIN1, GATE_PIN0, COUNT_PIN1, COUNT_PIN0};

  // three flops; level moves only when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          pin_s1_ff[gi]  <= 1'b0;
          pin_s2_ff[gi]  <= 1'b0;
          pin_s3_ff[gi]  <= 1'b0;
          pin_lvl_ff[gi] <= 1'b0;
        end else begin
          pin_s1_ff[gi] <= pin_raw[gi];
          pin_s2_ff[gi] <= pin_s1_ff[gi];
          pin_s3_ff[gi] <= pin_s2_ff[gi];
          if (pin_s2_ff[gi] == pin_s3_ff[gi]) begin
            pin_lvl_ff[gi] <= pin_s3_ff[gi];
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // peripheral cycle divider
  // ---------------------------------------------------------------
  // twelve oscillator clocks, or six in double speed
  assign div_last = (x2_ff ? `TMR_DIV_X2 : `TMR_DIV_STD) - 4'h1;

  // one tick per peripheral cycle
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      div_ff      <= 4'h0;
      per_tick_ff <= 1'b0;
    end else begin
      if (div_ff >= div_last) begin
        div_ff <= 4'h0;
      end else begin
        div_ff <= div_ff + 4'h1;
      end
      per_tick_ff <= (div_ff >= div_last);
    end
  end

  // ---------------------------------------------------------------
  // count pin sampling
  // ---------------------------------------------------------------
  // sample once per peripheral cycle
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sample0_ff <= 1'b0;
      sample1_ff <= 1'b0;
    end else if (per_tick_ff) begin
      sample0_ff <= pin_lvl_ff[0];
      sample1_ff <= pin_lvl_ff[1];
    end
  end

  // previous sample high, this sample low: one count
  assign edge0 = per_tick_ff & sample0_ff & ~pin_lvl_ff[0];
  assign edge1 = per_tick_ff & sample1_ff & ~pin_lvl_ff[1];

  // ---------------------------------------------------------------
  // input selection and gating
  // ---------------------------------------------------------------
  // source: peripheral cycle or count pin edge
  assign src0 = mode_ff[`TMR_SRC0] ? edge0 : per_tick_ff;
  assign src1 = mode_ff[`TMR_SRC1] ? edge1 : per_tick_ff;

  // per-unit gate enable and gate pin
  assign gate_ok0 = ~mode_ff[`TMR_GATE_ENABLE] | pin_lvl_ff[2];
  assign gate_ok1 = ~mode_ff[`TMR_GATE1] | pin_lvl_ff[3];

  // unit 0 split mode borrows unit 1 run bit and flag
  assign t0_split = (mode_ff[`TMR_MODE0_LSB+1:`TMR_MODE0_LSB] == `TMR_M_SPLIT);
  assign run1_eff = t0_split | run1_ff;

  // counted input passes only while running (unit 1 also with run clear while unit 0 splits) and gate allows; split high byte takes no gate
  assign tick0      = run0_ff & gate_ok0 & src0;
  assign tick1      = run1_eff & gate_ok1 & src1;
  assign tick0_high = run1_ff & per_tick_ff;

  // ---------------------------------------------------------------
  // count units
  // ---------------------------------------------------------------
  // unit 0: low mode nibble
  timer_count_unit u_unit0 (
    .clk       (CLK_SYS),
    .rst       (RST),
    .mode      (mode_ff[`TMR_MODE0_LSB+1:`TMR_MODE0_LSB]),
    .split     (1'b1),
    .tick_low  (tick0),
    .tick_high (tick0_high),
    .wr_low    (do_write & wlane_ff & (awaddr_ff == `TMR_ADDR_LOW0)),
    .wr_high   (do_write & wlane_ff & (awaddr_ff == `TMR_ADDR_HIGH0)),
    .wr_data   (wdata_ff),
    .low_ff    (low0),
    .high_ff   (high0),
    .ovf_low   (ovf0_low),
    .ovf_high  (ovf0_high)
  );

  // unit 1: high mode nibble; mode 3 holds the count
  timer_count_unit u_unit1 (
    .clk       (CLK_SYS),
    .rst       (RST),
    .mode      (mode_ff[`TMR_MODE1_LSB+1:`TMR_MODE1_LSB]),
    .split     (1'b0),
    .tick_low  (tick1),
    .tick_high (1'b0),
    .wr_low    (do_write & wlane_ff & (awaddr_ff == `TMR_ADDR_LOW1)),
    .wr_high   (do_write & wlane_ff & (awaddr_ff == `TMR_ADDR_HIGH1)),
    .wr_data   (wdata_ff),
    .low_ff    (low1),
    .high_ff   (high1),
    .ovf_low   (ovf1_low),
    .ovf_high  ()
  );

  // ---------------------------------------------------------------
  // overflow flags
  // ---------------------------------------------------------------
  assign set_ovf0 = ovf0_low;
  assign set_ovf1 = t0_split ? ovf0_high : ovf1_low;
  assign wr_ctrl  = do_write & wlane_ff & (awaddr_ff == `TMR_ADDR_CTRL);
  assign clr_ovf0 = VECTOR_ACK0 | (wr_ctrl & ~wdata_ff[`TMR_CTRL_OVF0]);
  assign clr_ovf1 = VECTOR_ACK1 | (wr_ctrl & ~wdata_ff[`TMR_CTRL_OVF1]);

  // set wins over any clear in the same cycle
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      OVF_IRQ0 <= 1'b0;
      OVF_IRQ1 <= 1'b0;
    end else begin
      if (set_ovf0) begin
        OVF_IRQ0 <= 1'b1;
      end else if (wr_ctrl & wdata_ff[`TMR_CTRL_OVF0]) begin
        OVF_IRQ0 <= 1'b1;
      end else if (clr_ovf0) begin
        OVF_IRQ0 <= 1'b0;
      end
      if (set_ovf1) begin
        OVF_IRQ1 <= 1'b1;
      end else if (wr_ctrl & wdata_ff[`TMR_CTRL_OVF1]) begin
        OVF_IRQ1 <= 1'b1;
      end else if (clr_ovf1) begin
        OVF_IRQ1 <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // control, mode and config registers
  // ---------------------------------------------------------------
  // run bits never touch the count bytes
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      run0_ff <= 1'b0;
      run1_ff <= 1'b0;
      mode_ff <= `TMR_RST_BYTE;
      x2_ff   <= 1'b0;
    end else if (do_write & wlane_ff) begin
      if (awaddr_ff == `TMR_ADDR_CTRL) begin
        run0_ff <= wdata_ff[`TMR_CTRL_RUN0];
        run1_ff <= wdata_ff[`TMR_CTRL_RUN1];
      end else if (awaddr_ff == `TMR_ADDR_MODE) begin
        mode_ff <= wdata_ff;
      end else if (awaddr_ff == `TMR_ADDR_CONFIG) begin
        x2_ff <= wdata_ff[`TMR_CFG_X2];
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  assign do_write = aw_got_ff & w_got_ff & ~BVALID;

  // address decode for the write response
  always @* begin
    if (awaddr_ff == `TMR_ADDR_CTRL) begin
      wr_hit = 1'b1;
    end else if (awaddr_ff == `TMR_ADDR_MODE) begin
      wr_hit = 1'b1;
    end else if (awaddr_ff == `TMR_ADDR_LOW0 || awaddr_ff == `TMR_ADDR_HIGH0) begin
      wr_hit = 1'b1;
    end else if (awaddr_ff == `TMR_ADDR_LOW1 || awaddr_ff == `TMR_ADDR_HIGH1) begin
      wr_hit = 1'b1;
    end else if (awaddr_ff == `TMR_ADDR_CONFIG) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // address and data taken in either order
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      AWREADY   <= 1'b1;
      WREADY    <= 1'b1;
      BVALID    <= 1'b0;
      BRESP     <= `TMR_RESP_OKAY;
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 8'h00;
      wlane_ff  <= 1'b0;
    end else begin
      if (AWREADY & AWVALID) begin
        AWREADY   <= 1'b0;
        aw_got_ff <= 1'b1;
        awaddr_ff <= {AWADDR[7:2], 2'b00};
      end
      if (WREADY & WVALID) begin
        WREADY   <= 1'b0;
        w_got_ff <= 1'b1;
        wdata_ff <= WDATA[7:0];
        wlane_ff <= WSTRB[0];
      end
      if (do_write) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        BVALID    <= 1'b1;
        BRESP     <= wr_hit ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
      end
      if (BVALID & BREADY) begin
        BVALID  <= 1'b0;
        AWREADY <= 1'b1;
        WREADY  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  // word-aligned read address
  assign rd_addr = {ARADDR[7:2], 2'b00};

  // read mux; count bytes readable at any time
  always @* begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    if (rd_addr == `TMR_ADDR_CTRL) begin
      rd_byte = {OVF_IRQ1, run1_ff, OVF_IRQ0, run0_ff, 4'h0};
    end else if (rd_addr == `TMR_ADDR_MODE) begin
      rd_byte = mode_ff;
    end else if (rd_addr == `TMR_ADDR_LOW0) begin
      rd_byte = low0;
    end else if (rd_addr == `TMR_ADDR_HIGH0) begin
      rd_byte = high0;
    end else if (rd_addr == `TMR_ADDR_LOW1) begin
      rd_byte = low1;
    end else if (rd_addr == `TMR_ADDR_HIGH1) begin
      rd_byte = high1;
    end else if (rd_addr == `TMR_ADDR_CONFIG) begin
      rd_byte = {7'h00, x2_ff};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // one read at a time; answer one edge after the address
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= `TMR_RESP_OKAY;
    end else begin
      if (ARREADY & ARVALID) begin
        ARREADY <= 1'b0;
        RVALID  <= 1'b1;
        RDATA   <= {24'h000000, rd_byte};
        RRESP   <= rd_hit ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
      end else if (RVALID & RREADY) begin
        RVALID  <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

endmodule

// File: rtl/timer_regs.vh
// Purpose: offsets, fields, reset values and counts of the timer pair
// Assumes: 32-bit AXI4-Lite data, registers in the low byte lane
// Notes:   definitions only
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define TMR_ADDR_CTRL     8'h00
`define TMR_ADDR_MODE     8'h04
`define TMR_ADDR_LOW0     8'h08
`define TMR_ADDR_HIGH0    8'h0c
`define TMR_ADDR_LOW1     8'h10
`define TMR_ADDR_HIGH1    8'h14
`define TMR_ADDR_CONFIG   8'h18

// ---------------------------------------------------------------
// control register bits
// ---------------------------------------------------------------
`define TMR_CTRL_RUN0     4
`define TMR_CTRL_OVF0     5
`define TMR_CTRL_RUN1     6
`define TMR_CTRL_OVF1     7

// ---------------------------------------------------------------
// mode register fields
// ---------------------------------------------------------------
`define TMR_MODE0_LSB     0
`define TMR_SRC0          2
`define TMR_GATE_ENABLE         3
`define TMR_MODE1_LSB     4
`define TMR_SRC1          6
`define TMR_GATE1         7

// mode pair encodings
`define TMR_M_13BIT       2'h0
`define TMR_M_16BIT       2'h1
`define TMR_M_RELOAD      2'h2
`define TMR_M_SPLIT       2'h3

// config register: double speed bit
`define TMR_CFG_X2        0

// ---------------------------------------------------------------
// reset values and timing counts
// ---------------------------------------------------------------
`define TMR_RST_BYTE      8'h00
// peripheral cycle = 6 peripheral clocks; osc/2 standard, osc in X2
`define TMR_DIV_STD       4'hc
`define TMR_DIV_X2        4'h6
`define TMR_RESP_OKAY     2'h0
`define TMR_RESP_SLVERR   2'h2

`endif

// File: rtl/timer_count_unit.v
// Purpose: one timer/counter: low and high count bytes, four modes
// Assumes: ticks already gated by run and gate logic
// Notes:   upper three low-byte bits hold their value in 13-bit mode
`timescale 1ns/10ps
`include "timer_regs.vh"

module timer_count_unit (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // configuration
  input  wire [1:0] mode,
  input  wire       split,
  // count events
  input  wire       tick_low,
  input  wire       tick_high,
  // software preset
  input  wire       wr_low,
  input  wire       wr_high,
  input  wire [7:0] wr_data,
  // state and overflow events
  output reg  [7:0] low_ff,
  output reg  [7:0] high_ff,
  output wire       ovf_low,
  output wire       ovf_high
);

  reg  [7:0] nxt_low;
  reg  [7:0] nxt_high;
  wire       low5_max = (low_ff[4:0] == 5'h1f);
  wire       low_max  = (low_ff == 8'hff);
  wire       high_max = (high_ff == 8'hff);
  wire       split_on = split & (mode == `TMR_M_SPLIT);

  // roll-over from all ones, per mode
  assign ovf_low = tick_low & ((mode == `TMR_M_13BIT)  ? (low5_max & high_max) :
                               (mode == `TMR_M_16BIT)  ? (low_max & high_max) :
                               (mode == `TMR_M_RELOAD) ? low_max :
                               (split_on & low_max));
  assign ovf_high = tick_high & split_on & high_max;

  // next count values
  always @* begin
    nxt_low  = low_ff;
    nxt_high = high_ff;
    if (tick_low) begin
      case (mode)
        `TMR_M_13BIT: begin
          nxt_low = {low_ff[7:5], low_ff[4:0] + 5'h01};
          if (low5_max) begin
            nxt_high = high_ff + 8'h01;
          end
        end
        `TMR_M_16BIT: begin
          nxt_low = low_ff + 8'h01;
          if (low_max) begin
            nxt_high = high_ff + 8'h01;
          end
        end
        `TMR_M_RELOAD: begin
          nxt_low = low_max ? high_ff : low_ff + 8'h01;
        end
        default: begin
          if (split_on) begin
            nxt_low = low_ff + 8'h01;
          end
        end
      endcase
    end
    if (tick_high & split_on) begin
      nxt_high = high_ff + 8'h01;
    end
    if (wr_low) begin
      nxt_low = wr_data;
    end
    if (wr_high) begin
      nxt_high = wr_data;
    end
  end

  // count byte flops
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      low_ff  <= `TMR_RST_BYTE;
      high_ff <= `TMR_RST_BYTE;
    end else begin
      low_ff  <= nxt_low;
      high_ff <= nxt_high;
    end
  end

endmodule

// File: testbench/timer_pair_props.sv
// Purpose: port assertions for the timer pair
// Assumes: one clock, reset active high
// Notes:   bound to every timer_pair instance
`timescale 1ns/10ps

module timer_pair_props (
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RST,
  // register bus
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic [7:0]  ARADDR,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP,
  input wire logic        RVALID,
  input wire logic        RREADY,
  // flags
  input wire logic        VECTOR_ACK0,
  input wire logic        VECTOR_ACK1,
  input wire logic        OVF_IRQ0,
  input wire logic        OVF_IRQ1
);
  default clocking dc @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  wr_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write answer not two edges after take");
  rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  rd_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped before taken");
  busy_ready_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write ready while answer pending");
  rd_upper_a: assert property (RVALID |-> RDATA[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  rd_resp_a: assert property ($rose(RVALID) |-> (RRESP == 2'h2) == ($past(ARADDR) > 8'h1b))
    else $error("read response does not match address");

  // ---------------------------------------------------------------
  // overflow flags
  // ---------------------------------------------------------------
  flag_fall_a: assert property ($fell(OVF_IRQ0) |-> $past(VECTOR_ACK0) || $rose(BVALID))
    else $error("flag 0 fell without cause");
  ack_clear_a: assert property (VECTOR_ACK1 && OVF_IRQ1 |=> !OVF_IRQ1)
    else $error("flag 1 not cleared by acknowledge");

  cover property ($rose(OVF_IRQ0));
  cover property ($rose(OVF_IRQ1));
  cover property (RVALID && RRESP == 2'h2);
endmodule

bind timer_pair timer_pair_props u_props (
  .CLK_SYS(CLK_SYS), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
  .WREADY(WREADY), .BVALID(BVALID), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
  .VECTOR_ACK0(VECTOR_ACK0), .VECTOR_ACK1(VECTOR_ACK1), .OVF_IRQ0(OVF_IRQ0),
  .OVF_IRQ1(OVF_IRQ1));

// File: testbench/pin_source.sv
// Purpose: event source and gate levels at the timer pins
// Assumes: levels change just after a clock edge
// Notes:   each count level held two peripheral cycles
`timescale 1ns/10ps

module pin_source (
  // clock
  input  wire logic CLK_SYS,
  // pins toward the timer pair
  output logic      COUNT_PIN0,
  output logic      COUNT_PIN1,
  output logic      GATE_PIN0,
  output logic      GATE_PIN1
);
  // idle: count pins high, gates open
  initial begin
    COUNT_PIN0 = 1'b1;
    COUNT_PIN1 = 1'b1;
    GATE_PIN0  = 1'b1;
    GATE_PIN1  = 1'b1;
  end

  // one level on a count pin
  task automatic level(input int unit, input logic v);
    @(posedge CLK_SYS);
    if (unit == 0) COUNT_PIN0 <= v;
    else COUNT_PIN1 <= v;
  endtask

  // n falling edges, each level held 24 clocks
  task automatic edges(input int unit, input int n);
    repeat (n) begin
      level(unit, 1'b0);
      repeat (23) @(posedge CLK_SYS);
      level(unit, 1'b1);
      repeat (23) @(posedge CLK_SYS);
    end
  endtask

  // gate pin level
  task automatic gate(input int unit, input logic v);
    @(posedge CLK_SYS);
    if (unit == 0) GATE_PIN0 <= v;
    else GATE_PIN1 <= v;
  endtask
endmodule

// File: testbench/timer_pair_tb.sv
// Purpose: self-checking bench for the timer pair
// Assumes: register access over AXI4-Lite, pins from pin_source
// Notes:   counter source gives exact counts, timer source a rate window
`timescale 1ns/10ps
`include "timer_regs.vh"

module timer_pair_tb;
  logic        CLK_SYS, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA;
  logic [3:0]  WSTRB;
  logic        VECTOR_ACK0, VECTOR_ACK1;
  wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, OVF_IRQ0, OVF_IRQ1;
  wire  [1:0]  BRESP, RRESP;
  wire  [31:0] RDATA;
  wire         COUNT_PIN0, COUNT_PIN1, GATE_PIN0, GATE_PIN1;
  logic [31:0] rd_val;
  logic [1:0]  resp;
  int          n_errors = 0;
  int          num_checks = 0;
  // counter cases: mode, presets, expected low, high, flag
  logic [7:0]  mode_t [5] = '{8'h40, 8'h50, 8'h60, 8'h50, 8'h70};
  logic [7:0]  lo_t   [5] = '{8'hfd, 8'hfe, 8'hfe, 8'h33, 8'h55};
  logic [7:0]  hi_t   [5] = '{8'hff, 8'h00, 8'hf0, 8'h44, 8'h66};
  logic [7:0]  elo_t  [5] = '{8'h00, 8'h01, 8'hf1, 8'h33, 8'h55};
  logic [7:0]  ehi_t  [5] = '{8'h00, 8'h01, 8'hf0, 8'h44, 8'h66};
  logic [7:0]  msk_t  [5] = '{8'h1f, 8'hff, 8'hff, 8'hff, 8'hff};
  logic        efl_t  [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  // 250 MHz clock
  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end

  timer_pair dut (
    .CLK_SYS(CLK_SYS), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .COUNT_PIN0(COUNT_PIN0), .COUNT_PIN1(COUNT_PIN1), .GATE_PIN0(GATE_PIN0),
    .GATE_PIN1(GATE_PIN1), .VECTOR_ACK0(VECTOR_ACK0), .VECTOR_ACK1(VECTOR_ACK1),
    .OVF_IRQ0(OVF_IRQ0), .OVF_IRQ1(OVF_IRQ1));

  pin_source ext (
    .CLK_SYS(CLK_SYS), .COUNT_PIN0(COUNT_PIN0), .COUNT_PIN1(COUNT_PIN1),
    .GATE_PIN0(GATE_PIN0), .GATE_PIN1(GATE_PIN1));

  // ---------------------------------------------------------------
  // compares and bus tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_rng(input logic [31:0] got, input logic [31:0] lo,
                           input logic [31:0] hi);
    num_checks++;
    if ((got ^ got) !== 32'h0 || got < lo || got > hi) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    AWADDR  <= a;
    WDATA   <= {24'h0, d};
    WSTRB   <= 4'h1;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    while (BVALID !== 1'b1) begin
      @(posedge CLK_SYS);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end
    BREADY <= 1'b1;
    @(posedge CLK_SYS);
    resp = BRESP;
    BREADY <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge CLK_SYS);
    ARADDR  <= a;
    ARVALID <= 1'b1;
    while (RVALID !== 1'b1) begin
      @(posedge CLK_SYS);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
    end
    RREADY <= 1'b1;
    @(posedge CLK_SYS);
    rd_val = RDATA;
    resp   = RRESP;
    RREADY <= 1'b0;
  endtask

  // one-cycle acknowledge pulse
  task automatic ack(input int unit);
    @(posedge CLK_SYS);
    if (unit == 0) VECTOR_ACK0 <= 1'b1;
    else VECTOR_ACK1 <= 1'b1;
    @(posedge CLK_SYS);
    VECTOR_ACK0 <= 1'b0;
    VECTOR_ACK1 <= 1'b0;
    @(posedge CLK_SYS);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    int t;
    int i;
    {AWADDR, ARADDR, WDATA, WSTRB} = '0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, VECTOR_ACK0, VECTOR_ACK1} = '0;
    RST = 1'b1;
    repeat (10) @(posedge CLK_SYS);
    RST <= 1'b0;
    // reset values, unmapped place
    for (i = 0; i < 7; i++) begin
      rd(8'(4 * i));
      check(rd_val, 32'h0);
    end
    rd(8'h1c);
    check(resp, 2'h2);
    wr(8'h1c, 8'hff);
    check(resp, 2'h2);
    $display("test reset_map done");
    // timer rate, standard and double speed
    for (i = 0; i < 2; i++) begin
      wr(`TMR_ADDR_CONFIG, 8'(i));
      wr(`TMR_ADDR_LOW0, 8'h00);
      wr(`TMR_ADDR_CTRL, 8'h10);
      repeat (120) @(posedge CLK_SYS);
      wr(`TMR_ADDR_CTRL, 8'h00);
      rd(`TMR_ADDR_LOW0);
      check_rng(rd_val & 32'h1f, 9 * (i + 1), 11 * (i + 1));
    end
    wr(`TMR_ADDR_CONFIG, 8'h00);
    $display("test rate done");
    // gate: own bit closed, other unit's bit, gate pin open
    ext.gate(0, 1'b0);
    for (i = 0; i < 3; i++) begin
      wr(`TMR_ADDR_MODE, i == 1 ? 8'h80 : 8'h08);
      if (i == 2) ext.gate(0, 1'b1);
      wr(`TMR_ADDR_LOW0, 8'h00);
      wr(`TMR_ADDR_CTRL, 8'h10);
      repeat (120) @(posedge CLK_SYS);
      wr(`TMR_ADDR_CTRL, 8'h00);
      rd(`TMR_ADDR_LOW0);
      check_rng(rd_val & 32'h1f, i == 0 ? 0 : 9, i == 0 ? 0 : 11);
    end
    $display("test gate done");
    // 13-bit roll-over from preset, upper low bits ignored
    wr(`TMR_ADDR_MODE, 8'h00);
    wr(`TMR_ADDR_HIGH0, 8'hff);
    wr(`TMR_ADDR_LOW0, 8'hde);
    wr(`TMR_ADDR_CTRL, 8'h10);
    for (t = 0; t < 60 && OVF_IRQ0 !== 1'b1; t++) @(posedge CLK_SYS);
    check(OVF_IRQ0, 1'b1);
    wr(`TMR_ADDR_CTRL, 8'h20);
    rd(`TMR_ADDR_HIGH0);
    check(rd_val, 32'h0);
    rd(`TMR_ADDR_LOW0);
    check_rng(rd_val & 32'h1f, 0, 2);
    rd(`TMR_ADDR_CTRL);
    check(rd_val, 32'h20);
    ack(0);
    check(OVF_IRQ0, 1'b0);
    $display("test overflow done");
    // counter source on unit 1 in modes 0, 1, 2, stopped and mode 3 hold
    for (i = 0; i < 5; i++) begin
      wr(`TMR_ADDR_CTRL, 8'h00);
      wr(`TMR_ADDR_MODE, mode_t[i]);
      wr(`TMR_ADDR_LOW1, lo_t[i]);
      wr(`TMR_ADDR_HIGH1, hi_t[i]);
      wr(`TMR_ADDR_CTRL, i == 3 ? 8'h00 : 8'h40);
      ext.edges(1, 3);
      check(OVF_IRQ1, efl_t[i]);
      ack(1);
      wr(`TMR_ADDR_CTRL, 8'h00);
      rd(`TMR_ADDR_LOW1);
      check(rd_val & msk_t[i], elo_t[i]);
      rd(`TMR_ADDR_HIGH1);
      check(rd_val, ehi_t[i]);
    end
    $display("test counter done");
    finish_test();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    n_errors++;
    finish_test();
  end
endmodule
